// ### pkg/wrtc_map.svh
// Register offsets, field positions, reset values and counts of the watch clock
`ifndef WRTC_MAP_SVH
`define WRTC_MAP_SVH
// ****************************************************
// Register offsets
// ****************************************************
`define WRTC_OFF_TIME 8'h00
`define WRTC_OFF_CTRL 8'h04
`define WRTC_OFF_STAT 8'h08
`define WRTC_OFF_MASK 8'h0C
`define WRTC_OFF_ALM0 8'h10
`define WRTC_OFF_ALM1 8'h14
`define WRTC_OFF_SWCH 8'h18
// ****************************************************
// Field positions
// ****************************************************
`define WRTC_SEC_POS 0
`define WRTC_MIN_POS 8
`define WRTC_HOUR_POS 16
`define WRTC_DAY_POS 24
`define WRTC_CTRL_RUN 0
`define WRTC_CTRL_A0EN 1
`define WRTC_CTRL_A1EN 2
`define WRTC_CTRL_SWEN 3
`define WRTC_EV_SEC 0
`define WRTC_EV_MIN 1
`define WRTC_EV_DAY 2
`define WRTC_EV_A0 3
`define WRTC_EV_A1 4
`define WRTC_EV_SW 5
`define WRTC_NUM_EV 6
// ****************************************************
// Reset values and counts
// ****************************************************
`define WRTC_CTRL_RST 4'h1
`define WRTC_MASK_RST 6'h00
`define WRTC_SW_RST 16'h0000
`define WRTC_TIME_RST 25'h0000000
`define WRTC_STAT_RST 6'h00
`define WRTC_XTAL_HZ 32'h00008000
`define WRTC_TICK_HZ 32'h00000001
`define WRTC_SEC_MAX 6'h3B
`define WRTC_MIN_MAX 6'h3B
`define WRTC_HOUR_MAX 5'h17
`endif

// ### pkg/wrtc_pkg.sv
// Types and field helpers of the watch clock
`include "wrtc_map.svh"
package wrtc_pkg;
  typedef struct packed {
    logic [7:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } wrtc_time_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wrtc_bus_req_t;

  typedef struct packed {
    logic sw_en;
    logic alarm1_en;
    logic alarm0_en;
    logic run;
  } wrtc_ctrl_t;

  function automatic logic [31:0] wrtc_pack_time(input wrtc_time_t t);
    logic [31:0] w;
    w = 32'h0;
    w[`WRTC_SEC_POS +: 6] = t.sec;
    w[`WRTC_MIN_POS +: 6] = t.min;
    w[`WRTC_HOUR_POS +: 5] = t.hour;
    w[`WRTC_DAY_POS +: 8] = t.day;
    return w;
  endfunction : wrtc_pack_time

  function automatic wrtc_time_t wrtc_unpack_time(input logic [31:0] w);
    wrtc_time_t t;
    t.sec = w[`WRTC_SEC_POS +: 6];
    t.min = w[`WRTC_MIN_POS +: 6];
    t.hour = w[`WRTC_HOUR_POS +: 5];
    t.day = w[`WRTC_DAY_POS +: 8];
    return t;
  endfunction : wrtc_unpack_time
endpackage : wrtc_pkg

// ### src/wrtc_top.sv
// Watch clock: prescaler, time of day counters, alarms, stopwatch, interrupts
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "wrtc_map.svh"

module wrtc_top import wrtc_pkg::*; #(
  parameter int unsigned PRESCALE_DIV = `WRTC_XTAL_HZ / `WRTC_TICK_HZ
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_xtal,
  input wire wrtc_bus_req_t i_bus,
  input wire logic i_low_power,
  input wire logic i_wake_en,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_wake
);
  // ****************************************************
  // Crystal sampling and prescaler
  // ****************************************************
  logic xtal_s1;
  logic xtal_s2;
  logic xtal_s3;
  logic [15:0] pre_cnt;
  logic [15:0] next_pre_cnt;
  logic xtal_rise;
  logic pre_last;
  logic sec_tick;

  assign xtal_rise = xtal_s2 & ~xtal_s3;
  assign pre_last = (pre_cnt == 16'(PRESCALE_DIV - 32'h00000001));
  assign sec_tick = xtal_rise & pre_last;

  always_comb begin
    next_pre_cnt = pre_cnt;
    if (xtal_rise) begin
      next_pre_cnt = pre_last ? 16'h0000 : pre_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      pre_cnt <= 16'h0000;
    end else begin
      xtal_s1 <= i_xtal;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      pre_cnt <= next_pre_cnt;
    end
  end

  // ****************************************************
  // Register write decode
  // ****************************************************
  logic wr_time;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_alm0;
  logic wr_alm1;
  logic wr_swch;

  assign wr_time = i_bus.wr && (i_bus.addr == `WRTC_OFF_TIME);
  assign wr_ctrl = i_bus.wr && (i_bus.addr == `WRTC_OFF_CTRL);
  assign wr_stat = i_bus.wr && (i_bus.addr == `WRTC_OFF_STAT);
  assign wr_mask = i_bus.wr && (i_bus.addr == `WRTC_OFF_MASK);
  assign wr_alm0 = i_bus.wr && (i_bus.addr == `WRTC_OFF_ALM0);
  assign wr_alm1 = i_bus.wr && (i_bus.addr == `WRTC_OFF_ALM1);
  assign wr_swch = i_bus.wr && (i_bus.addr == `WRTC_OFF_SWCH);

  // ****************************************************
  // Time of day counters
  // ****************************************************
  wrtc_time_t time_q;
  wrtc_time_t next_time;
  wrtc_ctrl_t ctrl;
  wrtc_ctrl_t next_ctrl;
  logic sec_evt;
  logic min_evt;
  logic day_evt;

  // Compare with >= so a bad software value still wraps instead of running to 63
  always_comb begin
    next_time = time_q;
    sec_evt = 1'b0;
    min_evt = 1'b0;
    day_evt = 1'b0;
    next_ctrl = wr_ctrl ? i_bus.wdata[3:0] : ctrl;
    if (wr_time) begin
      next_time = wrtc_unpack_time(i_bus.wdata);
    end else if (sec_tick && ctrl.run) begin
      sec_evt = 1'b1;
      if (time_q.sec >= `WRTC_SEC_MAX) begin
        next_time.sec = 6'h00;
        min_evt = 1'b1;
        if (time_q.min >= `WRTC_MIN_MAX) begin
          next_time.min = 6'h00;
          if (time_q.hour >= `WRTC_HOUR_MAX) begin
            next_time.hour = 5'h00;
            next_time.day = time_q.day + 8'h01;
            day_evt = 1'b1;
          end else begin
            next_time.hour = time_q.hour + 5'h01;
          end
        end else begin
          next_time.min = time_q.min + 6'h01;
        end
      end else begin
        next_time.sec = time_q.sec + 6'h01;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      time_q <= `WRTC_TIME_RST;
      ctrl <= `WRTC_CTRL_RST;
    end else begin
      time_q <= next_time;
      ctrl <= next_ctrl;
    end
  end

  // ****************************************************
  // Alarms and stopwatch
  // ****************************************************
  wrtc_time_t alm0;
  wrtc_time_t alm1;
  wrtc_time_t next_alm0;
  wrtc_time_t next_alm1;
  logic [15:0] sw_cnt;
  logic [15:0] next_sw_cnt;
  logic chk;
  logic match0;
  logic match1;
  logic sw_evt;

  // Compare one cycle after the tick, once the counters hold the new time
  assign match0 = (time_q.hour == alm0.hour) && (time_q.min == alm0.min) && (time_q.sec == alm0.sec);
  assign match1 = (time_q == alm1);

  always_comb begin
    next_alm0 = alm0;
    next_alm1 = alm1;
    next_sw_cnt = sw_cnt;
    sw_evt = 1'b0;
    if (wr_alm0) begin
      next_alm0 = wrtc_unpack_time(i_bus.wdata);
      next_alm0.day = 8'h00;
    end
    if (wr_alm1) begin
      next_alm1 = wrtc_unpack_time(i_bus.wdata);
    end
    if (wr_swch) begin
      next_sw_cnt = i_bus.wdata[15:0];
    end else if (min_evt && ctrl.sw_en) begin
      next_sw_cnt = sw_cnt - 16'h0001;
      sw_evt = (sw_cnt == 16'h0000);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      alm0 <= `WRTC_TIME_RST;
      alm1 <= `WRTC_TIME_RST;
      sw_cnt <= `WRTC_SW_RST;
      chk <= 1'b0;
    end else begin
      alm0 <= next_alm0;
      alm1 <= next_alm1;
      sw_cnt <= next_sw_cnt;
      chk <= sec_evt;
    end
  end

  // ****************************************************
  // Status, mask, interrupt and wake
  // ****************************************************
  logic [`WRTC_NUM_EV-1:0] evt;
  logic [`WRTC_NUM_EV-1:0] stat;
  logic [`WRTC_NUM_EV-1:0] next_stat;
  logic [`WRTC_NUM_EV-1:0] mask;
  logic [`WRTC_NUM_EV-1:0] next_mask;
  logic [`WRTC_NUM_EV-1:0] clr;
  logic next_irq;
  logic next_wake;

  always_comb begin
    evt = '0;
    evt[`WRTC_EV_SEC] = sec_evt;
    evt[`WRTC_EV_MIN] = min_evt;
    evt[`WRTC_EV_DAY] = day_evt;
    evt[`WRTC_EV_A0] = chk && ctrl.alarm0_en && match0;
    evt[`WRTC_EV_A1] = chk && ctrl.alarm1_en && match1;
    evt[`WRTC_EV_SW] = sw_evt;
    clr = wr_stat ? i_bus.wdata[`WRTC_NUM_EV-1:0] : '0;
    next_mask = wr_mask ? i_bus.wdata[`WRTC_NUM_EV-1:0] : mask;
    next_irq = |(next_stat & next_mask);
    next_wake = i_low_power && i_wake_en && (|(stat & mask));
  end

  // A new event beats a clear in the same cycle
  for (genvar k = 0; k < `WRTC_NUM_EV; k++) begin : g_stat
    assign next_stat[k] = evt[k] | (stat[k] & ~clr[k]);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stat <= `WRTC_STAT_RST;
      mask <= `WRTC_MASK_RST;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      stat <= next_stat;
      mask <= next_mask;
      o_irq <= next_irq;
      o_wake <= next_wake;
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `WRTC_OFF_TIME: next_rdata = wrtc_pack_time(time_q);
        `WRTC_OFF_CTRL: next_rdata = {28'h0, ctrl};
        `WRTC_OFF_STAT: next_rdata = {26'h0, stat};
        `WRTC_OFF_MASK: next_rdata = {26'h0, mask};
        `WRTC_OFF_ALM0: next_rdata = wrtc_pack_time(alm0);
        `WRTC_OFF_ALM1: next_rdata = wrtc_pack_time(alm1);
        `WRTC_OFF_SWCH: next_rdata = {16'h0, sw_cnt};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_tick_restart: assert property (sec_tick |=> pre_cnt == 16'h0000)
    else $error("prescaler did not restart after tick");
  a_pre_step: assert property (xtal_rise && !pre_last |=> pre_cnt == $past(pre_cnt) + 16'h0001)
    else $error("prescaler missed a crystal edge");
  a_sec_count: assert property (sec_tick && ctrl.run && !wr_time && time_q.sec < `WRTC_SEC_MAX
    |=> time_q.sec == $past(time_q.sec) + 6'h01 && time_q.min == $past(time_q.min))
    else $error("seconds did not advance by one");
  a_min_wrap: assert property (sec_tick && ctrl.run && !wr_time
    && time_q.sec == `WRTC_SEC_MAX && time_q.min < `WRTC_MIN_MAX
    |=> time_q.sec == 6'h00 && time_q.min == $past(time_q.min) + 6'h01 ##0 stat[`WRTC_EV_MIN])
    else $error("seconds wrap did not carry");
  a_hour_wrap: assert property (min_evt && time_q.min == `WRTC_MIN_MAX && time_q.hour == `WRTC_HOUR_MAX
    |=> time_q.hour == 5'h00 && stat[`WRTC_EV_DAY])
    else $error("hours wrap did not carry into days");
  // A time write in the tick cycle wins and swallows that tick
  a_periodic_sec: assert property (sec_tick && ctrl.run && !wr_time |=> stat[`WRTC_EV_SEC])
    else $error("second event not flagged");
  a_alarm0_fire: assert property (sec_tick && ctrl.run && ctrl.alarm0_en && !wr_time
    ##1 match0 && ctrl.alarm0_en |=> stat[`WRTC_EV_A0])
    else $error("daily alarm missed");
  a_alarm1_day: assert property (chk && time_q.day != alm1.day |=> $past(stat[`WRTC_EV_A1]) || !stat[`WRTC_EV_A1])
    else $error("day alarm fired on the wrong day");
  a_sw_dec: assert property (min_evt && ctrl.sw_en && sw_cnt != 16'h0000 && !wr_swch
    |=> sw_cnt == $past(sw_cnt) - 16'h0001)
    else $error("stopwatch did not count down");
  a_sw_under: assert property (min_evt && ctrl.sw_en && sw_cnt == 16'h0000 && !wr_swch
    |=> stat[`WRTC_EV_SW] && sw_cnt == 16'hFFFF)
    else $error("stopwatch underflow not flagged");
  a_sticky_hold: assert property (stat[`WRTC_EV_SW] && !(wr_stat && i_bus.wdata[`WRTC_EV_SW])
    |=> stat[`WRTC_EV_SW])
    else $error("status flag dropped without clear");
  a_irq_level: assert property (##1 o_irq == (|(stat & mask)))
    else $error("interrupt level does not follow status and mask");
  a_wake_req: assert property ((|(stat & mask)) && i_low_power && i_wake_en |=> o_wake)
    else $error("wake request missing");
  a_wake_gate: assert property (!i_wake_en |=> !o_wake)
    else $error("wake raised without enable");

  c_day_roll: cover property (day_evt);
  c_alarm1: cover property (evt[`WRTC_EV_A1]);
  c_sw_under: cover property (sw_evt ##1 o_irq);
  c_wake: cover property (o_wake);
endmodule : wrtc_top

// ### verif/tb_top.sv
// Self-checking bench of the watch clock: registers, time keeping, alarms, stopwatch, interrupts
`timescale 1ns/1ps
`include "wrtc_map.svh"
module tb_top import wrtc_pkg::*;;
  // ****************************************************
  // Clock, reset and stimulus signals
  // ****************************************************
  logic i_core_clk;
  logic i_srst;
  logic i_xtal;
  wrtc_bus_req_t bus;
  logic i_low_power;
  logic i_wake_en;
  logic [31:0] o_rdata;
  logic o_irq;
  logic o_wake;
  int err_total;
  int checks;

  // Short prescaler so one second is four crystal edges
  wrtc_top #(.PRESCALE_DIV(4)) dut (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_xtal(i_xtal),
    .i_bus(bus),
    .i_low_power(i_low_power),
    .i_wake_en(i_wake_en),
    .o_rdata(o_rdata),
    .o_irq(o_irq),
    .o_wake(o_wake)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge i_core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge i_core_clk);
    bus.rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rchk

  // Four crystal rises make one tick; the wait covers synchroniser and alarm latency
  task automatic tick();
    repeat (4) begin
      repeat (4) @(posedge i_core_clk);
      i_xtal <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      i_xtal <= 1'b0;
    end
    repeat (10) @(posedge i_core_clk);
  endtask : tick

  task automatic pins(input logic irq, input logic wake);
    repeat (3) @(posedge i_core_clk);
    #1;
    chk({31'h0, o_irq}, {31'h0, irq});
    chk({31'h0, o_wake}, {31'h0, wake});
    // Hand back on a rising edge so the next pin change lands on the clock
    @(posedge i_core_clk);
  endtask : pins

  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ****************************************************
  // Watchdog
  // ****************************************************
  initial begin
    #200000;
    err_total++;
    complete_run();
  end

  // ****************************************************
  // Tests
  // ****************************************************
  initial begin
    err_total = 0;
    checks = 0;
    i_srst = 1'b1;
    i_xtal = 1'b0;
    bus = '0;
    i_low_power = 1'b0;
    i_wake_en = 1'b0;
    repeat (16) @(posedge i_core_clk);
    i_srst <= 1'b0;
    // Reset values, unmapped address reads zero
    rchk(`WRTC_OFF_CTRL, 32'h00000001);
    rchk(`WRTC_OFF_STAT, 32'h00000000);
    rchk(`WRTC_OFF_MASK, 32'h00000000);
    rchk(`WRTC_OFF_TIME, 32'h00000000);
    rchk(`WRTC_OFF_ALM0, 32'h00000000);
    rchk(`WRTC_OFF_ALM1, 32'h00000000);
    rchk(`WRTC_OFF_SWCH, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rchk(8'h1C, 32'h00000000);
    pins(1'b0, 1'b0);
    // Full rollover from day 5 23:59:59
    wr(`WRTC_OFF_MASK, 32'h0000003F);
    rchk(`WRTC_OFF_MASK, 32'h0000003F);
    wr(`WRTC_OFF_TIME, 32'h05173B3B);
    rchk(`WRTC_OFF_TIME, 32'h05173B3B);
    tick();
    rchk(`WRTC_OFF_TIME, 32'h06000000);
    rchk(`WRTC_OFF_STAT, 32'h00000007);
    pins(1'b1, 1'b0);
    // Wake needs low power and the external enable
    i_low_power <= 1'b1;
    pins(1'b1, 1'b0);
    i_wake_en <= 1'b1;
    pins(1'b1, 1'b1);
    // Write one to clear: bit 0 alone, then bits 1 and 2 together
    wr(`WRTC_OFF_STAT, 32'h00000001);
    rchk(`WRTC_OFF_STAT, 32'h00000006);
    wr(`WRTC_OFF_STAT, 32'h00000006);
    rchk(`WRTC_OFF_STAT, 32'h00000000);
    pins(1'b0, 1'b0);
    // Alarm 0 on time of day, alarm 1 on day and time
    wr(`WRTC_OFF_ALM0, 32'h00000001);
    wr(`WRTC_OFF_ALM1, 32'h06000002);
    rchk(`WRTC_OFF_ALM1, 32'h06000002);
    wr(`WRTC_OFF_CTRL, 32'h00000007);
    tick();
    rchk(`WRTC_OFF_STAT, 32'h00000009);
    tick();
    rchk(`WRTC_OFF_STAT, 32'h00000019);
    // Another day: the daily alarm recurs; the single tick stops before the alarm 1 time
    wr(`WRTC_OFF_TIME, 32'h07000000);
    wr(`WRTC_OFF_STAT, 32'h0000003F);
    tick();
    rchk(`WRTC_OFF_STAT, 32'h00000009);
    // Alarm disabled gives no alarm flag
    wr(`WRTC_OFF_CTRL, 32'h00000001);
    wr(`WRTC_OFF_TIME, 32'h07000000);
    wr(`WRTC_OFF_STAT, 32'h0000003F);
    tick();
    rchk(`WRTC_OFF_STAT, 32'h00000001);
    // Masked event sets status but leaves the pins low
    wr(`WRTC_OFF_MASK, 32'h00000000);
    wr(`WRTC_OFF_STAT, 32'h0000003F);
    tick();
    rchk(`WRTC_OFF_STAT, 32'h00000001);
    pins(1'b0, 1'b0);
    // Stopwatch counts minutes down and flags the underflow
    wr(`WRTC_OFF_MASK, 32'h00000020);
    wr(`WRTC_OFF_SWCH, 32'h00000001);
    wr(`WRTC_OFF_CTRL, 32'h00000009);
    wr(`WRTC_OFF_TIME, 32'h0000003B);
    wr(`WRTC_OFF_STAT, 32'h0000003F);
    tick();
    rchk(`WRTC_OFF_SWCH, 32'h00000000);
    rchk(`WRTC_OFF_STAT, 32'h00000003);
    pins(1'b0, 1'b0);
    wr(`WRTC_OFF_TIME, 32'h0000003B);
    tick();
    rchk(`WRTC_OFF_SWCH, 32'h0000FFFF);
    rchk(`WRTC_OFF_STAT, 32'h00000023);
    pins(1'b1, 1'b1);
    // Stopped clock: no advance, no events
    wr(`WRTC_OFF_CTRL, 32'h00000000);
    tick();
    rchk(`WRTC_OFF_TIME, 32'h00000100);
    rchk(`WRTC_OFF_STAT, 32'h00000023);
    rchk(`WRTC_OFF_SWCH, 32'h0000FFFF);
    complete_run();
  end
endmodule : tb_top
